// ---- include/spicfg_pkg.sv ----
// Purpose: constants and types for the serial port configuration block
// Assumes: 8-bit registers, 15-bit register addresses
// Notes: one instruction = R/W bit plus 15-bit address, then data bytes
package spicfg_pkg;
  localparam logic [14:0] ADDR_CONFIG_A = 15'h0000;
  localparam logic [14:0] ADDR_CONFIG_B = 15'h0001;
  localparam int BIT_RESET_REQUEST = 0;
  localparam int BIT_LOW_BIT_ORDER = 1;
  localparam int BIT_ADDRESS_STEP = 2;
  localparam int BIT_FOUR_WIRE = 3;
  localparam int BIT_SECONDARY_ZERO = 1;
  localparam int BIT_SECONDARY_ONE = 2;
  localparam int BIT_CS_STALL = 6;
  localparam int BIT_SINGLE_INSTR = 7;
  localparam logic [7:0] RESET_CONFIG_A = 8'h00;
  localparam logic [7:0] RESET_CONFIG_B = 8'h00;
  localparam logic [7:0] CONFIG_B_WRITE_MASK = 8'hFE;
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;
  localparam logic [3:0] PULSE_CYCLES = 4'h1;
  typedef enum logic [1:0] {
    SPICFG_INSTR,
    SPICFG_DATA,
    SPICFG_IDLE
  } spicfg_phase_t;
endpackage

// ---- include/spicfg_link_if.sv ----
// Purpose: carries synchronised pin samples to the main logic
// Assumes: both ends on ref_clk
// Notes: edges are single-cycle pulses
`timescale 1ns/100ps
interface spicfg_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic cs_start;
  logic data_in;
  modport producer (output sclk_rise, output sclk_fall, output cs_active,
    output cs_start, output data_in);
  modport consumer (input sclk_rise, input sclk_fall, input cs_active,
    input cs_start, input data_in);
endinterface

// ---- verilog/spicfg_pin_sync.sv ----
// Purpose: two-flop synchronisers and edge detection for serial pins
// Assumes: pins are asynchronous to ref_clk
// Notes: edge detectors read the second stage and its one-cycle delayed copy, never the first stage
`timescale 1ns/100ps
module spicfg_pin_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  spicfg_link_if.producer link
);
  logic [2:0] meta;
  logic [2:0] stable;
  logic [1:0] prev;
  logic [2:0] next_meta;
  logic [2:0] next_stable;
  logic [1:0] next_prev;

  always_comb begin
    next_meta = {sclk, cs_n, sdio_in};
    next_stable = meta;
    next_prev = stable[2:1];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta <= 3'h2;
      stable <= 3'h2;
      prev <= 2'h1;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign link.sclk_rise = stable[2] & ~prev[1] & ~stable[1];
  assign link.sclk_fall = ~stable[2] & prev[1] & ~stable[1];
  assign link.cs_active = ~stable[1];
  assign link.cs_start = ~stable[1] & prev[0];
  assign link.data_in = stable[0];
endmodule

// ---- verilog/spicfg_port.sv ----
// Purpose: serial control port with its interface configuration registers
// Assumes: mode 0 (sample on sclk rise, shift out on fall), cs_n active low
// Notes: only the two configuration registers are held; others read 0x00
`timescale 1ns/100ps
module spicfg_port
  import spicfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo,
  output logic sdo_oe,
  output logic soft_reset,
  output logic secondary_reset_zero,
  output logic secondary_reset_one,
  output logic [7:0] config_a,
  output logic [7:0] config_b
);
  spicfg_link_if link ();

  spicfg_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdio_in(sdio_in),
    .link(link.producer)
  );

  spicfg_phase_t phase, next_phase;
  logic [15:0] shift, next_shift;
  logic [4:0] count, next_count;
  logic reading, next_reading;
  logic [14:0] addr, next_addr;
  logic [7:0] tx, next_tx;
  logic [3:0] low_a, next_low_a;
  logic [7:0] reg_b, next_reg_b;
  logic [3:0] rst_cnt, next_rst_cnt;
  logic [3:0] pulse_cnt, next_pulse_cnt;
  logic load_tx, next_load_tx;
  logic next_sdio_out, next_sdio_oe, next_sdo, next_sdo_oe;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic [15:0] instr_word;
  logic lsb_first;
  logic [14:0] stepped;

  assign lsb_first = low_a[BIT_LOW_BIT_ORDER];

  always_comb begin
    wr_byte = shift[7:0];
    instr_word = shift;
    if (lsb_first) begin
      for (int i = 0; i < 8; i++) begin
        wr_byte[i] = shift[7 - i];
      end
      for (int i = 0; i < 16; i++) begin
        instr_word[i] = shift[15 - i];
      end
    end
  end

  always_comb begin
    unique case (addr)
      ADDR_CONFIG_A: rd_byte = {low_a[0], low_a[1], low_a[2], low_a[3],
        low_a[3:0]};
      ADDR_CONFIG_B: rd_byte = reg_b;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    if (low_a[BIT_ADDRESS_STEP]) begin
      stepped = addr + 15'h0001;
    end else begin
      stepped = addr - 15'h0001;
    end
  end

  always_comb begin
    next_phase = phase;
    next_shift = shift;
    next_count = count;
    next_reading = reading;
    next_addr = addr;
    next_tx = tx;
    next_low_a = low_a;
    next_reg_b = reg_b;
    next_rst_cnt = rst_cnt;
    next_pulse_cnt = pulse_cnt;
    next_load_tx = 1'b0;
    next_sdio_out = sdio_out;
    next_sdio_oe = 1'b0;
    next_sdo = sdo;
    next_sdo_oe = 1'b0;
    if (rst_cnt != 4'h0) begin
      next_rst_cnt = rst_cnt - 4'h1;
      if (rst_cnt == 4'h1) begin
        next_low_a = RESET_CONFIG_A[3:0];
        next_reg_b = RESET_CONFIG_B;
      end
    end
    if (pulse_cnt != 4'h0) begin
      next_pulse_cnt = pulse_cnt - 4'h1;
      if (pulse_cnt == 4'h1) begin
        next_reg_b[BIT_SECONDARY_ONE] = 1'b0;
        next_reg_b[BIT_SECONDARY_ZERO] = 1'b0;
      end
    end
    if (!link.cs_active || link.cs_start) begin
      next_phase = SPICFG_INSTR;
      next_count = 5'h00;
      next_shift = 16'h0000;
    end else begin
      if (reading && phase == SPICFG_DATA) begin
        next_sdo_oe = low_a[BIT_FOUR_WIRE];
        next_sdio_oe = ~low_a[BIT_FOUR_WIRE];
      end
      if (link.sclk_rise && phase != SPICFG_IDLE) begin
        next_shift = {shift[14:0], link.data_in};
        next_count = count + 5'h01;
      end
      if (link.sclk_fall && reading && phase == SPICFG_DATA) begin
        next_sdio_out = lsb_first ? tx[0] : tx[7];
        next_sdo = next_sdio_out;
        next_tx = lsb_first ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
      end
      if (phase == SPICFG_INSTR && count == 5'h10) begin
        next_reading = instr_word[15];
        next_addr = instr_word[14:0];
        next_phase = SPICFG_DATA;
        next_count = 5'h00;
        next_load_tx = 1'b1;
      end else if (phase == SPICFG_DATA && count == 5'h08) begin
        next_count = 5'h00;
        next_load_tx = 1'b1;
        if (!reading && addr == ADDR_CONFIG_A) begin
          next_low_a = wr_byte[3:0];
          if (wr_byte[BIT_RESET_REQUEST]) begin
            next_rst_cnt = SOFT_RESET_CYCLES;
          end
        end else if (!reading && addr == ADDR_CONFIG_B) begin
          next_reg_b = wr_byte & CONFIG_B_WRITE_MASK;
          if (wr_byte[BIT_SECONDARY_ONE] || wr_byte[BIT_SECONDARY_ZERO]) begin
            next_pulse_cnt = PULSE_CYCLES;
          end
        end
        next_addr = stepped;
        if (reg_b[BIT_SINGLE_INSTR]) begin
          next_phase = SPICFG_IDLE;
        end
      end
    end
    // Load transmit byte once, after the new address stands
    if (load_tx && reading && phase == SPICFG_DATA) begin
      next_tx = rd_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase <= SPICFG_INSTR;
      shift <= 16'h0000;
      count <= 5'h00;
      reading <= 1'b0;
      addr <= 15'h0000;
      tx <= 8'h00;
      low_a <= 4'h0;
      reg_b <= 8'h00;
      rst_cnt <= 4'h0;
      pulse_cnt <= 4'h0;
      load_tx <= 1'b0;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      soft_reset <= 1'b0;
      secondary_reset_zero <= 1'b0;
      secondary_reset_one <= 1'b0;
      config_a <= 8'h00;
      config_b <= 8'h00;
    end else begin
      phase <= next_phase;
      shift <= next_shift;
      count <= next_count;
      reading <= next_reading;
      addr <= next_addr;
      tx <= next_tx;
      low_a <= next_low_a;
      reg_b <= next_reg_b;
      rst_cnt <= next_rst_cnt;
      pulse_cnt <= next_pulse_cnt;
      load_tx <= next_load_tx;
      sdio_out <= next_sdio_out;
      sdio_oe <= next_sdio_oe;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      soft_reset <= next_rst_cnt != 4'h0;
      secondary_reset_zero <= next_reg_b[BIT_SECONDARY_ZERO];
      secondary_reset_one <= next_reg_b[BIT_SECONDARY_ONE];
      config_a <= {next_low_a[0], next_low_a[1], next_low_a[2],
        next_low_a[3], next_low_a};
      config_b <= next_reg_b;
    end
  end
endmodule

// ---- testbench/spicfg_port_assertions.sv ----
// Purpose: port checks for the serial configuration block
// Assumes: one clock domain, rst active high
// Notes: bound to spicfg_port below
`timescale 1ns/100ps
module spicfg_port_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sdio_oe,
  input wire logic sdo_oe,
  input wire logic soft_reset,
  input wire logic secondary_reset_zero,
  input wire logic secondary_reset_one,
  input wire logic [7:0] config_a,
  input wire logic [7:0] config_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  mirror_bits_a: assert property (config_a[7:4] ==
    {config_a[0], config_a[1], config_a[2], config_a[3]}) else $error("mirror");
  sdo_mode_a: assert property (sdo_oe |-> config_a[3])
    else $error("sdo mode");
  shared_mode_a: assert property (sdio_oe |-> !config_a[3])
    else $error("sdio mode");
  oe_exclusive_a: assert property (!(sdo_oe && sdio_oe))
    else $error("both enables");
  soft_len_a: assert property ($rose(soft_reset) |->
    soft_reset[*8] ##1 !soft_reset) else $error("soft length");
  soft_clear_a: assert property ($fell(soft_reset) |->
    ##[0:2] (config_a == 8'h00 && config_b == 8'h00)) else $error("clear");
  one_pulse_a: assert property ($rose(secondary_reset_one) |=>
    !secondary_reset_one) else $error("pulse one");
  zero_pulse_a: assert property ($rose(secondary_reset_zero) |=>
    !secondary_reset_zero) else $error("pulse zero");
endmodule
bind spicfg_port spicfg_port_assertions spicfg_port_assertions_i (.ref_clk,
  .rst, .sdio_oe, .sdo_oe, .soft_reset, .secondary_reset_zero,
  .secondary_reset_one, .config_a, .config_b);

// ---- testbench/spicfg_host_model.sv ----
// Purpose: host controller driving the serial pins
// Assumes: mode 0, sclk idles low, 160 ns bit
// Notes: idle data line toggles every cycle
`timescale 1ns/100ps
module spicfg_host_model (
  input wire logic ref_clk,
  input wire logic sdo,
  input wire logic sdio_out,
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic sdio_in
);
  logic idle_bit = 1'b0;
  logic data_bit = 1'b0;
  // Idle line toggles, frame line carries the data bit
  assign sdio_in = cs_n ? idle_bit : data_bit;
  always @(posedge ref_clk)
    idle_bit <= ~idle_bit;
  // First data byte sits in the low byte
  task automatic xfer(input logic [15:0] ins, input int n,
    input logic [15:0] wd, input logic lsb, input logic w,
    output logic [15:0] rd);
    int p;
    rd = 16'h0000;
    cs_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 16 + 8 * n; i++) begin
      p = (i / 8 - 2) * 8 + (lsb ? i % 8 : 7 - i % 8);
      if (i < 16)
        data_bit <= lsb ? ins[i] : ins[15 - i];
      else
        data_bit <= ins[15] ? ~data_bit : wd[p];
      repeat (8) @(posedge ref_clk);
      sclk <= 1'b1;
      if (i >= 16)
        rd[p] = w ? sdo : sdio_out;
      repeat (8) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (16) @(posedge ref_clk);
  endtask
endmodule

// ---- testbench/tb_spicfg_port.sv ----
// Purpose: self-checking bench for the configuration port
// Assumes: host model drives the serial pins
// Notes: fixed-seed shift register for random bits
`timescale 1ns/100ps
module tb_spicfg_port;
  import spicfg_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  bad_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
  logic ref_clk, sclk, cs_n, sdio_in, sdio_out, sdio_oe, sdo, sdo_oe;
  logic soft_reset, secondary_reset_zero, secondary_reset_one;
  logic rst = 1'b1;
  logic lsb = 1'b0;
  logic [7:0] config_a, config_b, ea;
  logic [15:0] rd;
  logic [31:0] seed = 32'h35E7;
  int bad_count = 0, check_count = 0, n0 = 0, n1 = 0, ns = 0;
  spicfg_port spicfg_port_i (.ref_clk, .rst, .sclk, .cs_n, .sdio_in,
    .sdio_out, .sdio_oe, .sdo, .sdo_oe, .soft_reset, .secondary_reset_zero,
    .secondary_reset_one, .config_a, .config_b);
  // Released data lines read low, so a missing enable shows up
  spicfg_host_model spicfg_host_model_i (.ref_clk, .sdo(sdo & sdo_oe),
    .sdio_out(sdio_out & sdio_oe), .sclk, .cs_n, .sdio_in);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] mir(input logic [3:0] n);
    return {n[0], n[1], n[2], n[3], n};
  endfunction
  task automatic wr(input logic [14:0] ad, input logic [15:0] d, int n);
    spicfg_host_model_i.xfer({1'b0, ad}, n, d, lsb, 1'b0, rd);
  endtask
  task automatic results;
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    n0 += secondary_reset_zero;
    n1 += secondary_reset_one;
    ns += soft_reset;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK(config_a, RESET_CONFIG_A)
    `CHK(config_b, RESET_CONFIG_B)
    wr(ADDR_CONFIG_B, 16'h0040, 1);
    // Every mode mix, read back as a two-byte stream
    for (int v = 0; v < 8; v++) begin
      seed = lfsr(seed);
      wr(ADDR_CONFIG_A, {8'h00, seed[3:0], v[2:0], 1'b0}, 1);
      ea = mir({v[2:0], 1'b0});
      lsb = v[0];
      `CHK(config_a, ea)
      spicfg_host_model_i.xfer({1'b1, v[1] ? ADDR_CONFIG_A : ADDR_CONFIG_B},
        2, 16'h0000, lsb, v[2], rd);
      `CHK(rd, v[1] ? {8'h40, ea} : {ea, 8'h40})
    end
    wr(ADDR_CONFIG_B, 16'h00C0, 1);
    seed = lfsr(seed);
    wr(ADDR_CONFIG_A, {1'b0, seed[6:0], 8'h0E}, 2);
    `CHK(config_b, 8'hC0)
    wr(ADDR_CONFIG_B, 16'h0000, 1);
    wr(ADDR_CONFIG_B, 16'h0004, 1);
    wr(ADDR_CONFIG_B, 16'h0002, 1);
    `CHK(n1, PULSE_CYCLES)
    `CHK(n0, PULSE_CYCLES)
    `CHK(config_b, 8'h00)
    wr(ADDR_CONFIG_A, 16'h0001, 1);
    repeat (30) @(posedge ref_clk);
    `CHK(ns, SOFT_RESET_CYCLES)
    `CHK(config_a, RESET_CONFIG_A)
    results();
  end
endmodule
